// ---- hw/ssp_top.sv ----
// Pair of synchronous serial ports with companding and multichannel mode
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        sclk_in,
  output logic      [1:0]        sclk_out,
  output logic      [1:0]        sclk_oe,
  input  wire logic [1:0]        rfs_in,
  output logic      [1:0]        rfs_out,
  output logic      [1:0]        rfs_oe,
  input  wire logic [1:0]        tfs_in,
  output logic      [1:0]        tfs_out,
  output logic      [1:0]        tfs_oe,
  input  wire logic [1:0]        dr_in,
  output logic      [1:0]        dt_out,
  output logic      [1:0]        dt_oe,
  input  wire logic [1:0]        cfg_int_clk,
  input  wire logic [1:0][15:0]  cfg_clk_div,
  input  wire logic [1:0][3:0]   cfg_len_m1,
  input  wire logic [1:0][1:0]   cfg_compand,
  input  wire logic [1:0][7:0]   cfg_buf_len,
  input  wire logic [1:0]        tx_en,
  input  wire logic [1:0]        tx_framed,
  input  wire logic [1:0]        tx_int_fs,
  input  wire logic [1:0]        tx_fs_inv,
  input  wire logic [1:0]        tx_fs_late,
  input  wire logic [1:0]        tx_autobuf,
  input  wire logic [1:0]        rx_en,
  input  wire logic [1:0]        rx_framed,
  input  wire logic [1:0]        rx_int_fs,
  input  wire logic [1:0]        rx_fs_inv,
  input  wire logic [1:0]        rx_fs_late,
  input  wire logic [1:0]        rx_autobuf,
  input  wire logic              mc_en,
  input  wire logic              mc_32,
  input  wire logic [31:0]       mc_tx_slots,
  input  wire logic [31:0]       mc_rx_slots,
  input  wire logic              alt_en_b,
  input  wire logic              flag_out_b,
  output logic                   flag_in_b,
  output logic                   alt_ext_interrupt_a,
  output logic                   alt_ext_interrupt_b,
  input  wire logic [15:0]       tx_a_data,
  input  wire logic              tx_a_valid,
  output logic                   tx_a_ready,
  input  wire logic [15:0]       tx_b_data,
  input  wire logic              tx_b_valid,
  output logic                   tx_b_ready,
  output logic      [1:0][15:0]  rx_data,
  output logic      [1:0]        rx_valid,
  input  wire logic [1:0]        rx_read,
  output logic      [1:0]        tx_irq,
  output logic      [1:0]        rx_irq
);

  ssp_state_type s;
  ssp_state_type next_s;

  ssp_stream_if #(.W(WORD_W)) fill_s ();
  ssp_stream_if #(.W(WORD_W)) drain_s ();

  // ----------------------------------------------------------------
  // Companding functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] ssp_mu_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0]  seg;
    mag = x[15] ? 16'(-x) : x;
    if (mag > MU_CLIP)
      mag = MU_CLIP;
    mag = 16'(mag + MU_BIAS);
    seg = '0;
    for (int i = 0; i < SEG_N; i++)
      if (mag[i + int'(MU_SEG_LSB)])
        seg = 3'(i);
    return ~{x[15], seg, 4'(mag >> (5'(seg) + MU_MANT_SH))};
  endfunction

  function automatic logic [15:0] ssp_mu_dec(input logic [7:0] c);
    logic [7:0]  u;
    logic [15:0] t;
    u = ~c;
    t = 16'(((16'(u[3:0]) << MU_MANT_SH) + MU_BIAS) << u[6:4]);
    t = 16'(t - MU_BIAS);
    return u[7] ? 16'(-t) : t;
  endfunction

  function automatic logic [7:0] ssp_al_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0]  seg;
    logic [3:0]  mant;
    mag = (x[15] ? 16'(-x) : x) >> AL_PRE_SH;
    if (mag > AL_CLIP)
      mag = AL_CLIP;
    seg = '0;
    for (int i = 1; i < SEG_N; i++)
      if (mag[i + int'(AL_SEG_LSB)])
        seg = 3'(i);
    mant = (mag < AL_SEG0) ? 4'(mag >> 1) : 4'(mag >> seg);
    return {!x[15], seg, mant} ^ AL_XOR;
  endfunction

  function automatic logic [15:0] ssp_al_dec(input logic [7:0] c);
    logic [7:0]  a;
    logic [15:0] t;
    a = c ^ AL_XOR;
    t = 16'((16'(a[3:0]) << AL_SEG_LSB) + AL_HALF);
    if (a[6:4] != '0)
      t = 16'((t + AL_STEP) << (a[6:4] - 3'h1));
    return a[7] ? t : 16'(-t);
  endfunction

  // Companding on the way in and out
  function automatic logic [15:0] ssp_compress(input logic [1:0] m, input logic [15:0] w);
    case (m)
      CMP_MU:   return {8'h00, ssp_mu_enc(w)};
      CMP_ALAW: return {8'h00, ssp_al_enc(w)};
      default:  return w;
    endcase
  endfunction

  function automatic logic [15:0] ssp_expand(input logic [1:0] m, input logic [15:0] w);
    case (m)
      CMP_MU:   return ssp_mu_dec(w[7:0]);
      CMP_ALAW: return ssp_al_dec(w[7:0]);
      default:  return w;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Transmit FIFO in front of port A
  // ----------------------------------------------------------------
  assign fill_s.data   = tx_a_data;
  assign fill_s.valid  = tx_a_valid;
  assign tx_a_ready    = fill_s.ready;
  assign drain_s.ready = !s.port[PORT_A].tx.full;
  assign tx_b_ready    = !s.port[PORT_B].tx.full;

  ssp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk   (clk),
    .rst   (rst),
    .in_s  (fill_s),
    .out_s (drain_s)
  );

  // ----------------------------------------------------------------
  // Next-state logic for both ports
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        rise, fall, mc, alt, te, re, ft, fr;
    logic        free_e, free_l, cont, ready, gen, fsv, strt, last;
    logic        src_v;
    logic [3:0]  len;
    logic [4:0]  lslot;
    logic [15:0] word, src_d;
    rise = 1'h0; fall = 1'h0; mc = 1'h0; alt = 1'h0; te = 1'h0; re = 1'h0;
    ft = 1'h0; fr = 1'h0; free_e = 1'h0; free_l = 1'h0; cont = 1'h0;
    ready = 1'h0; gen = 1'h0; fsv = 1'h0; strt = 1'h0; last = 1'h0;
    src_v = 1'h0; len = '0; lslot = '0; word = '0; src_d = '0;
    next_s = s;
    // Alternate pin functions of port B, sampled live
    next_s.irq_a    = alt_en_b && !rfs_in[PORT_B];
    next_s.irq_b    = alt_en_b && !tfs_in[PORT_B];
    next_s.flag_in  = dr_in[PORT_B];
    next_s.flag_out = flag_out_b;
    for (int p = 0; p < PORTS; p++)
    begin
      next_s.port[p].tx.irq = 1'h0;
      next_s.port[p].rx.irq = 1'h0;
      len   = (cfg_len_m1[p] < MIN_LEN_M1) ? MIN_LEN_M1 : cfg_len_m1[p];
      mc    = (p == PORT_A) && mc_en;
      alt   = (p == PORT_B) && alt_en_b;
      lslot = mc_32 ? SLOT_LAST_32 : SLOT_LAST_24;
      te    = tx_en[p] && !alt;
      re    = rx_en[p] && !alt;
      ft    = tx_framed[p] || mc;
      fr    = rx_framed[p] || mc;
      // Serial clock: divider or edges of external clock
      next_s.port[p].sclk_q = sclk_in[p];
      if (cfg_int_clk[p])
      begin
        if (s.port[p].div == '0)
        begin
          next_s.port[p].div  = cfg_clk_div[p];
          next_s.port[p].sclk = !s.port[p].sclk;
          rise = !s.port[p].sclk;
          fall = s.port[p].sclk;
        end
        else
        begin
          next_s.port[p].div = s.port[p].div - DIV_STEP;
          rise = 1'h0;
          fall = 1'h0;
        end
      end
      else
      begin
        rise = sclk_in[p] && !s.port[p].sclk_q;
        fall = !sclk_in[p] && s.port[p].sclk_q;
      end
      // Transmit holding register fill
      src_v = (p == PORT_A) ? drain_s.valid : tx_b_valid;
      src_d = (p == PORT_A) ? drain_s.data : tx_b_data;
      if (!s.port[p].tx.full && src_v)
      begin
        next_s.port[p].tx.hold = ssp_compress(cfg_compand[p], src_d);
        next_s.port[p].tx.full = 1'h1;
      end
      // Transmit shifter, driven on rising serial clock
      free_e = !s.port[p].tx.active || (s.port[p].tx.rem <= REM_LAST);
      free_l = !s.port[p].tx.active || (s.port[p].tx.rem == '0);
      cont   = mc && s.port[p].tx.active && (s.port[p].tx.rem == '0)
               && (s.port[p].tx.slot != lslot);
      ready  = mc || s.port[p].tx.full;
      gen    = ready && !s.port[p].tx.pend && !cont && (tx_fs_late[p] ? free_l : free_e);
      if (!te)
      begin
        next_s.port[p].tx.active = 1'h0;
        next_s.port[p].tx.pend   = 1'h0;
        next_s.port[p].tx.fs     = 1'h0;
      end
      else if (rise)
      begin
        next_s.port[p].tx.fs = ft && tx_int_fs[p] && gen;
        fsv  = (ft && tx_int_fs[p]) ? gen : (tfs_in[p] ^ tx_fs_inv[p]);
        strt = s.port[p].tx.pend || cont
               || (ft ? (tx_fs_late[p] && fsv && ready && free_l) : (ready && free_l));
        if (strt)
        begin
          next_s.port[p].tx.pend    = 1'h0;
          next_s.port[p].tx.slot    = cont ? 5'(s.port[p].tx.slot + SLOT_ONE) : '0;
          next_s.port[p].tx.en_slot = !mc || mc_tx_slots[next_s.port[p].tx.slot];
          last = next_s.port[p].tx.en_slot && s.port[p].tx.full;
          word = last ? s.port[p].tx.hold : '0;
          next_s.port[p].tx.shift  = word << (MSB_IDX - len);
          next_s.port[p].tx.rem    = len;
          next_s.port[p].tx.active = 1'h1;
          if (last)
          begin
            next_s.port[p].tx.full = 1'h0;
            last = !tx_autobuf[p] || (s.port[p].tx.wcnt == 8'(cfg_buf_len[p] - BUF_ONE));
            next_s.port[p].tx.irq  = last;
            next_s.port[p].tx.wcnt = last ? '0 : 8'(s.port[p].tx.wcnt + BUF_ONE);
          end
        end
        else
        begin
          if (s.port[p].tx.active && (s.port[p].tx.rem != '0))
          begin
            next_s.port[p].tx.shift = {s.port[p].tx.shift[14:0], 1'h0};
            next_s.port[p].tx.rem   = s.port[p].tx.rem - REM_LAST;
          end
          else
          begin
            next_s.port[p].tx.active = 1'h0;
          end
          if (ft && !tx_fs_late[p] && fsv && ready && free_e && !s.port[p].tx.pend)
            next_s.port[p].tx.pend = 1'h1;
        end
      end
      // Receive frame generation on rising serial clock
      cont = mc && s.port[p].rx.active && (s.port[p].rx.rem == '0)
             && (s.port[p].rx.slot != lslot);
      free_e = !s.port[p].rx.active || (s.port[p].rx.rem <= REM_LAST);
      free_l = !s.port[p].rx.active || (s.port[p].rx.rem == '0);
      if (rx_read[p])
        next_s.port[p].rx.full = 1'h0;
      if (!re)
      begin
        next_s.port[p].rx.active = 1'h0;
        next_s.port[p].rx.pend   = 1'h0;
        next_s.port[p].rx.fs     = 1'h0;
      end
      else if (rise)
      begin
        next_s.port[p].rx.fs = fr && rx_int_fs[p] && !s.port[p].rx.pend && !cont
                               && (rx_fs_late[p] ? free_l : free_e);
      end
      else if (fall)
      begin
        // Receive shifter, sampled on falling serial clock
        fsv  = (fr && rx_int_fs[p]) ? s.port[p].rx.fs : (rfs_in[p] ^ rx_fs_inv[p]);
        strt = s.port[p].rx.pend || cont || (fr ? (rx_fs_late[p] && fsv && free_l) : free_l);
        last = 1'h0;
        if (strt)
        begin
          next_s.port[p].rx.pend   = 1'h0;
          next_s.port[p].rx.slot   = cont ? 5'(s.port[p].rx.slot + SLOT_ONE) : '0;
          next_s.port[p].rx.shift  = {15'h0000, dr_in[p]};
          next_s.port[p].rx.rem    = len;
          next_s.port[p].rx.active = 1'h1;
        end
        else
        begin
          if (s.port[p].rx.active && (s.port[p].rx.rem != '0))
          begin
            next_s.port[p].rx.shift = {s.port[p].rx.shift[14:0], dr_in[p]};
            next_s.port[p].rx.rem   = s.port[p].rx.rem - REM_LAST;
            last = (s.port[p].rx.rem == REM_LAST);
          end
          else
          begin
            next_s.port[p].rx.active = 1'h0;
          end
          if (fr && !rx_fs_late[p] && fsv && free_e && !s.port[p].rx.pend)
            next_s.port[p].rx.pend = 1'h1;
        end
        // Word complete: load receive buffer, new word wins over read
        if (last && (!mc || mc_rx_slots[s.port[p].rx.slot]))
        begin
          next_s.port[p].rx.hold = ssp_expand(cfg_compand[p], next_s.port[p].rx.shift);
          next_s.port[p].rx.full = 1'h1;
          last = !rx_autobuf[p] || (s.port[p].rx.wcnt == 8'(cfg_buf_len[p] - BUF_ONE));
          next_s.port[p].rx.irq  = last;
          next_s.port[p].rx.wcnt = last ? '0 : 8'(s.port[p].rx.wcnt + BUF_ONE);
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Pin and user-side outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      sclk_out[p] = s.port[p].sclk;
      sclk_oe[p]  = cfg_int_clk[p];
      rfs_out[p]  = s.port[p].rx.fs ^ rx_fs_inv[p];
      tfs_out[p]  = s.port[p].tx.fs ^ tx_fs_inv[p];
      rfs_oe[p]   = (rx_framed[p] || ((p == PORT_A) && mc_en)) && rx_int_fs[p]
                    && !((p == PORT_B) && alt_en_b);
      tfs_oe[p]   = (tx_framed[p] || ((p == PORT_A) && mc_en)) && tx_int_fs[p]
                    && !((p == PORT_B) && alt_en_b);
      dt_out[p]   = s.port[p].tx.shift[WORD_W-1];
      dt_oe[p]    = !((p == PORT_A) && mc_en) || (s.port[p].tx.active && s.port[p].tx.en_slot);
      rx_data[p]  = s.port[p].rx.hold;
      rx_valid[p] = s.port[p].rx.full;
      tx_irq[p]   = s.port[p].tx.irq;
      rx_irq[p]   = s.port[p].rx.irq;
    end
    // Port B data pin carries the output flag in alternate mode
    if (alt_en_b)
    begin
      dt_out[PORT_B] = s.flag_out;
      dt_oe[PORT_B]  = 1'h1;
    end
  end

  assign flag_in_b           = s.flag_in;
  assign alt_ext_interrupt_a = s.irq_a;
  assign alt_ext_interrupt_b = s.irq_b;

endmodule

// ---- hw/ssp_pkg.sv ----
// Shared constants and types for the serial port pair
// Behaviour
// - Separate double-buffered transmit and receive per port
// - Serial clock internal divider or external input
// - Framing configured separately per direction
// - Frameless or framed, frame internal or external
// - Frame polarity and early/late timing selectable
// - Word length programmable from 3 to 16
// - Optional A-law or mu-law companding
// - Distinct transmit and receive word interrupts
// - Buffered mode interrupts only after whole buffer
// - Port A multichannel with 24 or 32 slots
// - Port B frame/data pins become interrupts, flags
// - Port B internal clock stays on pin
// - Pin function switchable at any time
// - Codec frame one bit before word start with early timing, on the first bit with late timing
package ssp_pkg;

  // ----------------------------------------------------------------
  // Sizes and indices
  // ----------------------------------------------------------------
  localparam int PORTS      = 2;
  localparam int PORT_A     = 0;
  localparam int PORT_B     = 1;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SEG_N      = 8;

  localparam logic [3:0]  MIN_LEN_M1   = 4'h2;
  localparam logic [3:0]  MSB_IDX      = 4'hF;
  localparam logic [3:0]  REM_LAST     = 4'h1;
  localparam logic [15:0] DIV_STEP     = 16'h0001;
  localparam logic [7:0]  BUF_ONE      = 8'h01;
  localparam logic [4:0]  SLOT_LAST_24 = 5'h17;
  localparam logic [4:0]  SLOT_LAST_32 = 5'h1F;
  localparam logic [4:0]  SLOT_ONE     = 5'h01;

  // ----------------------------------------------------------------
  // Companding modes and constants
  // ----------------------------------------------------------------
  localparam logic [1:0]  CMP_NONE   = 2'h0;
  localparam logic [1:0]  CMP_MU     = 2'h2;
  localparam logic [1:0]  CMP_ALAW   = 2'h3;
  localparam logic [15:0] MU_CLIP    = 16'h7F7B;
  localparam logic [15:0] MU_BIAS    = 16'h0084;
  localparam logic [4:0]  MU_SEG_LSB = 5'h07;
  localparam logic [4:0]  MU_MANT_SH = 5'h03;
  localparam logic [4:0]  AL_PRE_SH  = 5'h03;
  localparam logic [4:0]  AL_SEG_LSB = 5'h04;
  localparam logic [15:0] AL_CLIP    = 16'h0FFF;
  localparam logic [15:0] AL_SEG0    = 16'h0020;
  localparam logic [15:0] AL_HALF    = 16'h0008;
  localparam logic [15:0] AL_STEP    = 16'h0100;
  localparam logic [7:0]  AL_XOR     = 8'h55;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] hold;
    logic        full;
    logic [15:0] shift;
    logic [3:0]  rem;
    logic        active;
    logic        pend;
    logic        fs;
    logic [4:0]  slot;
    logic        en_slot;
    logic [7:0]  wcnt;
    logic        irq;
  } ssp_sec_type;

  typedef struct packed {
    logic        sclk;
    logic        sclk_q;
    logic [15:0] div;
    ssp_sec_type tx;
    ssp_sec_type rx;
  } ssp_port_type;

  typedef struct packed {
    ssp_port_type [1:0] port;
    logic               irq_a;
    logic               irq_b;
    logic               flag_in;
    logic               flag_out;
  } ssp_state_type;

endpackage

// ---- hw/ssp_stream_if.sv ----
// Valid/ready word stream between the port logic and its FIFO
interface ssp_stream_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ---- hw/ssp_fifo.sv ----
// Parameterised valid/ready FIFO
module ssp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  ssp_stream_if.snk in_s,
  ssp_stream_if.src out_s
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wptr;
    logic [AW:0]             rptr;
  } ssp_fifo_state_type;

  ssp_fifo_state_type s;
  ssp_fifo_state_type next_s;

  logic full;
  logic empty;

  // ----------------------------------------------------------------
  // Flags and handshakes
  // ----------------------------------------------------------------
  assign empty = (s.wptr == s.rptr);
  assign full  = (s.wptr[AW-1:0] == s.rptr[AW-1:0]) && (s.wptr[AW] != s.rptr[AW]);
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = s.mem[s.rptr[AW-1:0]];

  // Write and read pointer update
  always_comb
  begin
    next_s = s;
    if (in_s.valid && !full)
    begin
      next_s.mem[s.wptr[AW-1:0]] = in_s.data;
      next_s.wptr = s.wptr + 1'h1;
    end
    if (out_s.ready && !empty)
    begin
      next_s.rptr = s.rptr + 1'h1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule

// ---- testbench/ssp_top_asserts.sv ----
// Checker on the top ports of the serial port pair
module ssp_top_asserts
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] cfg_int_clk,
  input wire logic [1:0] sclk_oe,
  input wire logic       alt_en_b,
  input wire logic [1:0] rfs_in,
  input wire logic [1:0] tfs_in,
  input wire logic       alt_ext_interrupt_a,
  input wire logic       alt_ext_interrupt_b,
  input wire logic [1:0] dr_in,
  input wire logic       flag_in_b,
  input wire logic       flag_out_b,
  input wire logic [1:0] dt_out,
  input wire logic [1:0] tx_irq,
  input wire logic [1:0] rx_valid,
  input wire logic [1:0] rx_read,
  input wire logic       tx_b_valid,
  input wire logic       tx_b_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Steps and properties
  // ------------------------------------------------------------
  sequence b_take;
    tx_b_valid && tx_b_ready;
  endsequence
  sequence alt_held;
    alt_en_b && $past(alt_en_b) && !$past(rst);
  endsequence
  clk_dir_a: assert property (sclk_oe == cfg_int_clk) else $error("clk dir");
  alt_clk_a: assert property (alt_en_b && cfg_int_clk[1] |-> sclk_oe[1])
    else $error("alt clk");
  irq_pin_a: assert property (
    !$past(rst) |-> alt_ext_interrupt_a == $past(alt_en_b && !rfs_in[1]))
    else $error("irq a");
  irq_pin_b: assert property (
    !$past(rst) |-> alt_ext_interrupt_b == $past(alt_en_b && !tfs_in[1]))
    else $error("irq b");
  flag_in_a: assert property (alt_held |-> flag_in_b == $past(dr_in[1]))
    else $error("flag in");
  flag_out_a: assert property (alt_held |-> dt_out[1] == $past(flag_out_b))
    else $error("flag out");
  tx_pulse_a: assert property (tx_irq[1] |=> !tx_irq[1]) else $error("tx irq");
  rx_hold_a: assert property (rx_valid[0] && !rx_read[0] |=> rx_valid[0])
    else $error("rx lost");
  b_full_a: assert property (b_take |=> !tx_b_ready) else $error("b refill");
endmodule

bind ssp_top ssp_top_asserts i_ssp_top_asserts (.clk, .rst, .cfg_int_clk, .sclk_oe,
  .alt_en_b, .rfs_in, .tfs_in, .alt_ext_interrupt_a, .alt_ext_interrupt_b, .dr_in,
  .flag_in_b, .flag_out_b, .dt_out, .tx_irq, .rx_valid, .rx_read, .tx_b_valid, .tx_b_ready);

// ---- testbench/ssp_codec_model.sv ----
// Codec model on one port: echoes data and frame, captures words
module ssp_codec_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        dt,
  input  wire logic        dt_oe,
  input  wire logic        tfs,
  input  wire logic        inv,
  input  wire logic        late,
  input  wire logic [4:0]  len,
  output logic             dr,
  output logic             rfs,
  output logic      [15:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q;
  logic       last;
  logic [4:0] cnt;
  logic       fs;
  // Echo; a released line shows the inverse of its last level
  assign dr  = dt_oe ? dt : ~last;
  assign rfs = tfs;
  assign fs  = tfs ^ inv;
  // Capture on falling serial edges
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
    if (dt_oe)
      last <= dt;
    if (rst)
      cnt <= 5'h00;
    else if (sclk_q && !sclk)
    begin
      if (cnt != 5'h00 || (fs && late))
        word <= {word[14:0], dt};
      if (fs)
        cnt <= late ? len - 5'h01 : len;
      else if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
    end
  end
endmodule

// ---- testbench/tb_ssp_top.sv ----
// Testbench: serial port pair looped through codec models
module tb_ssp_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst, alt_en_b, flag_out_b, flag_in_b, mc_en, mc_32;
  logic             alt_ext_interrupt_a, alt_ext_interrupt_b, rq_a_n, pin_dr_b;
  logic             tx_a_valid, tx_a_ready, tx_b_valid, tx_b_ready;
  logic [1:0]       sclk_in, sclk_out, sclk_oe, rfs_in, rfs_out, rfs_oe, tfs_in, tfs_out;
  logic [1:0]       tfs_oe, dr_in, dt_out, dt_oe, cfg_int_clk, tx_en, tx_framed, tx_int_fs;
  logic [1:0]       tx_fs_inv, tx_fs_late, tx_autobuf, rx_en, rx_framed, rx_int_fs;
  logic [1:0]       rx_fs_inv, rx_fs_late, rx_autobuf, rx_valid, rx_read, tx_irq, rx_irq;
  logic [1:0]       p_dr, p_rfs;
  logic [31:0]      mc_tx_slots, mc_rx_slots;
  logic [15:0]      tx_a_data, tx_b_data, alt_pins;
  logic [1:0][15:0] cfg_clk_div, rx_data, p_word;
  logic [1:0][3:0]  cfg_len_m1;
  logic [1:0][1:0]  cfg_compand;
  logic [1:0][7:0]  cfg_buf_len;
  int               n_mismatch, comparisons, n_txi, n_rxi;

  ssp_top i_ssp_top (.clk, .rst, .sclk_in, .sclk_out, .sclk_oe, .rfs_in, .rfs_out, .rfs_oe,
    .tfs_in, .tfs_out, .tfs_oe, .dr_in, .dt_out, .dt_oe, .cfg_int_clk, .cfg_clk_div,
    .cfg_len_m1, .cfg_compand, .cfg_buf_len, .tx_en, .tx_framed, .tx_int_fs, .tx_fs_inv,
    .tx_fs_late, .tx_autobuf, .rx_en, .rx_framed, .rx_int_fs, .rx_fs_inv, .rx_fs_late,
    .rx_autobuf, .mc_en, .mc_32, .mc_tx_slots, .mc_rx_slots, .alt_en_b, .flag_out_b,
    .flag_in_b, .alt_ext_interrupt_a, .alt_ext_interrupt_b, .tx_a_data, .tx_a_valid,
    .tx_a_ready, .tx_b_data, .tx_b_valid, .tx_b_ready, .rx_data, .rx_valid, .rx_read,
    .tx_irq, .rx_irq);

  for (genvar p = 0; p < 2; p++)
  begin : g_codec
    ssp_codec_model i_ssp_codec_model (.clk, .rst, .sclk(sclk_out[p]), .dt(dt_out[p]),
      .dt_oe(dt_oe[p]), .tfs(tfs_out[p]), .inv(tx_fs_inv[p]), .late(tx_fs_late[p]),
      .len({1'b0, cfg_len_m1[p]} + 5'h01), .dr(p_dr[p]), .rfs(p_rfs[p]), .word(p_word[p]));
  end

  // Codec lines, or interrupt and flag pins while port B is switched over
  assign dr_in    = alt_en_b ? {pin_dr_b, p_dr[0]} : p_dr;
  assign rfs_in   = alt_en_b ? {rq_a_n, p_rfs[0]} : p_rfs;
  assign alt_pins = {8'h0, rfs_oe[1], tfs_oe[1], dt_oe[1], sclk_oe[1], alt_ext_interrupt_a,
                     alt_ext_interrupt_b, dt_out[1], flag_in_b};

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send_b(input logic [15:0] w);
    int n = 0;
    tx_b_data  = w;
    tx_b_valid = 1'b1;
    while (tx_b_ready !== 1'b1 && n < 500)
    begin
      @(posedge clk) #1;
      n++;
    end
    check({15'h0, tx_b_ready}, 16'h0001);
    @(posedge clk) #1;
    tx_b_valid = 1'b0;
  endtask

  task automatic recv(input int p, input logic [15:0] exp, input logic [15:0] mask);
    int n = 0;
    do
    begin
      @(posedge clk) #1;
      n++;
    end
    while (rx_valid[p] !== 1'b1 && n < 500);
    check({15'h0, rx_valid[p]}, 16'h0001);
    check(rx_data[p], exp & mask);
    rx_read[p] = 1'b1;
    @(posedge clk) #1;
    rx_read[p] = 1'b0;
    // Codec model sees the last falling edge one clock after the port
    check(p_word[p] & mask, exp & mask);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Clock and interrupt pulse counters of port B
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk)
  begin
    n_txi += tx_irq[1];
    n_rxi += rx_irq[1];
  end

  // Watchdog, about ten times the expected run
  initial
  begin
    #2_000_000;
    n_mismatch++;
    report_and_stop();
  end

  // -----------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------
  initial
  begin
    logic [15:0] mask;
    logic [15:0] w[4];
    int          len[4];
    int          n;
    w   = '{16'hB2C5, 16'h0005, 16'h00A6, 16'h0F3C};
    len = '{16, 3, 8, 12};
    {rst, alt_en_b, flag_out_b, mc_en, mc_32, tx_a_valid, tx_b_valid} = 7'h40;
    {rq_a_n, pin_dr_b, tfs_in, sclk_in, rx_read} = 8'hB0;
    {cfg_int_clk, tx_en, rx_en, tx_framed, rx_framed, tx_int_fs, rx_int_fs} = 14'h3FFC;
    {tx_fs_inv, rx_fs_inv, tx_fs_late, rx_fs_late, tx_autobuf, rx_autobuf} = 12'h550;
    {mc_tx_slots, mc_rx_slots, tx_a_data, tx_b_data} = '0;
    {cfg_clk_div, cfg_len_m1, cfg_compand, cfg_buf_len} = {32'h0001_0001, 8'hFF, 4'h0, 16'h0202};
    repeat (3) @(posedge clk) #1;
    check({12'h0, sclk_out, rx_valid}, 16'h0000);
    check({14'h0, tx_a_ready, tx_b_ready}, 16'h0003);
    repeat (3) @(posedge clk) #1;
    rst = 1'b0;
    // Word lengths on port B, junk in the unused upper bits
    n_txi = 0;
    n_rxi = 0;
    for (int i = 0; i < 4; i++)
    begin
      cfg_len_m1[1] = 4'(len[i] - 1);
      mask = 16'((17'h1 << len[i]) - 17'h1);
      send_b(w[i] | ~mask);
      recv(1, w[i], mask);
    end
    check(16'(n_txi), 16'h0004);
    check(16'(n_rxi), 16'h0004);
    // Port B pins switched to interrupts and flags while running
    {alt_en_b, rq_a_n, flag_out_b, pin_dr_b} = 4'b1011;
    repeat (2) @(posedge clk) #1;
    check(alt_pins, 16'h003B);
    {rq_a_n, flag_out_b, pin_dr_b, tfs_in[1]} = 4'b1000;
    repeat (2) @(posedge clk) #1;
    check(alt_pins, 16'h0034);
    {alt_en_b, tfs_in[1], tx_autobuf[1], rx_autobuf[1]} = 4'b0111;
    cfg_len_m1[1] = 4'hF;
    // Buffered transfers: one interrupt per two words each way
    n_txi = 0;
    n_rxi = 0;
    for (int i = 0; i < 4; i++)
    begin
      send_b(16'h8421 << i);
      recv(1, 16'h8421 << i, 16'hFFFF);
    end
    check(16'(n_txi), 16'h0002);
    check(16'(n_rxi), 16'h0002);
    // Port A through its FIFO: fill until refused, drain in order
    n = 0;
    tx_a_data  = 16'h1000;
    tx_a_valid = 1'b1;
    while (tx_a_ready === 1'b1 && n < 40)
    begin
      @(posedge clk) #1;
      n++;
      tx_a_data = 16'h1000 + 16'(n);
    end
    tx_a_valid = 1'b0;
    check(16'(n >= 16 && n <= 18), 16'h0001);
    for (int i = 0; i < n; i++)
      recv(0, 16'h1000 + 16'(i), 16'hFFFF);
    report_and_stop();
  end
endmodule
